/* File: inc/msps_consts.vh */
// How it works
// - pcs status bit 15 latches sync loss
// - pcs status bit 14 latches invalid code-group
// - bit 12 sets on sgmii alignment error
// - bit 11 shows partner aneg restart request
// - bits 9:8 show remote fault, zero none
// - bits 7:4 show mac pause/duplex abilities
// - bit 3 shows partner aneg capable
// - bit 2 shows link up
// - bit 1 shows aneg complete
// - bit 0 shows signal detect
// - advertised word resets zero, writable when forced
// - unforced protocol-transfer read value is undefined
// - partner register holds last received word
// - serial bit 15 latches comma realign, read-clears
// - serial bit 14 latches signal detection, read-clears
// - serial bit 13 qsgmii sync, first port
// - bit 12 comma detect, read sets 1 unless comma missing
// - bits 11:8 comma position 0 to 9
// - counter bit 15 shows counter active
// - bits 13:0 count good packets modulo 10000
// - control bit 11 forces software advertised word
// - counters count only while media link up
`ifndef MSPS_CONSTS_VH
`define MSPS_CONSTS_VH
`define MSPS_ADDR_W 5
`define MSPS_OFF_CTRL 5'h10
`define MSPS_OFF_PCS_STATUS 5'h11
`define MSPS_OFF_ADV 5'h12
`define MSPS_OFF_PARTNER 5'h13
`define MSPS_OFF_SERIAL 5'h14
`define MSPS_OFF_TXCNT 5'h15
`define MSPS_CTRL_FORCE_BIT 11
`define MSPS_CTRL_MASK 16'h0800
`define MSPS_ADV_RESET 16'h0000
`define MSPS_CNT_W 14
`define MSPS_CNT_MAX 14'h270f
`define MSPS_POS_MAX 4'h9
`define MSPS_POS_W 4
`define MSPS_DATA_W 16
`define MSPS_ZERO16 16'h0000
`define MSPS_LP_RESET 16'h0000
`define MSPS_COMMA_RESET 1'b1
`define MSPS_PCS_SYNC_BIT 15
`define MSPS_PCS_CGBAD_BIT 14
`define MSPS_PCS_ALIGN_BIT 12
`define MSPS_PCS_RESTART_BIT 11
`define MSPS_PCS_RF_HI 9
`define MSPS_PCS_RF_LO 8
`define MSPS_PCS_ABIL_HI 7
`define MSPS_PCS_ABIL_LO 4
`define MSPS_PCS_LPCAP_BIT 3
`define MSPS_PCS_LINK_BIT 2
`define MSPS_PCS_ANEG_BIT 1
`define MSPS_PCS_SIGDET_BIT 0
`define MSPS_SER_REALIGN_BIT 15
`define MSPS_SER_SIGEVT_BIT 14
`define MSPS_SER_QSYNC_BIT 13
`define MSPS_SER_COMMA_BIT 12
`define MSPS_SER_POS_HI 11
`define MSPS_SER_POS_LO 8
`define MSPS_CNT_ACT_BIT 15
`endif

/* File: src/msps_status_regs.v */
// The plain strobed port was chosen for this implementation.
`include "msps_consts.vh"

module msps_status_regs
(
  // clock and reset
  input wire sys_clk_in,
  input wire resetn_in,
  // register port
  input wire [`MSPS_ADDR_W-1:0] addr_in,
  input wire [15:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [15:0] rdata_out,
  // pcs events, one-cycle pulses
  input wire sync_lost_in,
  input wire cgbad_in,
  input wire align_err_in,
  input wire comma_realign_in,
  input wire sig_det_event_in,
  // pcs levels
  input wire lp_aneg_restart_in,
  input wire [1:0] remote_fault_in,
  input wire [3:0] mac_ability_in,
  input wire lp_aneg_capable_in,
  input wire link_up_in,
  input wire aneg_done_in,
  input wire sig_det_in,
  input wire qsgmii_sync_in,
  input wire comma_det_in,
  input wire [3:0] comma_pos_in,
  input wire is_first_port_in,
  input wire qsgmii_mode_in,
  // code words
  input wire [15:0] adv_live_in,
  input wire lp_word_valid_in,
  input wire [15:0] lp_word_in,
  // packet counter
  input wire tx_good_pkt_in,
  input wire media_link_up_in,
  // to pcs
  output wire force_adv_out,
  output reg [15:0] adv_word_out
);

  // stored control and code word state
  reg force_adv;
  reg [`MSPS_DATA_W-1:0] adv_sw;
  reg [`MSPS_DATA_W-1:0] lp_word;

  // since-last-read flags; alignment error holds until reset
  reg sync_lost_l;
  reg cgbad_l;
  reg align_err_l;
  reg realign_l;
  reg sig_evt_l;
  reg comma_l;

  // packet count and read path
  reg [`MSPS_CNT_W-1:0] pkt_cnt;
  reg [`MSPS_CNT_W-1:0] next_pkt_cnt;
  reg [`MSPS_DATA_W-1:0] next_rdata;
  reg [`MSPS_DATA_W-1:0] ctrl_word;
  reg [`MSPS_DATA_W-1:0] pcs_word;
  reg [`MSPS_DATA_W-1:0] ser_word;
  reg [`MSPS_DATA_W-1:0] cnt_word;

  // decoded strobes and selects
  wire rd_pcs;
  wire rd_ser;
  wire wr_ctrl;
  wire wr_adv;
  wire cnt_step;
  wire [`MSPS_DATA_W-1:0] adv_sel;

  // address match, shared by the read and write decoders
  function hit;
    input [`MSPS_ADDR_W-1:0] addr;
    input [`MSPS_ADDR_W-1:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // sticky update: a new event outranks the clearing read
  function sticky_next;
    input held;
    input evt_now;
    input clear_now;
    begin
      sticky_next = evt_now | (held & ~clear_now);
    end
  endfunction

  // word the pcs advertises: software copy only when forced
  function [`MSPS_DATA_W-1:0] adv_pick;
    input forced;
    input [`MSPS_DATA_W-1:0] sw_word;
    input [`MSPS_DATA_W-1:0] live_word;
    begin
      if (forced)
        adv_pick = sw_word;
      else
        adv_pick = live_word;
    end
  endfunction

  // comma position saturates at the last legal slot
  function [`MSPS_POS_W-1:0] pos_clamp;
    input [`MSPS_POS_W-1:0] pos;
    begin
      if (pos > `MSPS_POS_MAX)
        pos_clamp = `MSPS_POS_MAX;
      else
        pos_clamp = pos;
    end
  endfunction

  // decimal wrap of the packet count
  function [`MSPS_CNT_W-1:0] cnt_inc;
    input [`MSPS_CNT_W-1:0] cnt;
    begin
      if (cnt == `MSPS_CNT_MAX)
        cnt_inc = {`MSPS_CNT_W{1'b0}};
      else
        cnt_inc = cnt + {{(`MSPS_CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // read strobes that clear latched flags
  assign rd_pcs = rd_in && hit(addr_in, `MSPS_OFF_PCS_STATUS);
  assign rd_ser = rd_in && hit(addr_in, `MSPS_OFF_SERIAL);

  // write strobes; the word is refused unless forced
  assign wr_ctrl = wr_in && hit(addr_in, `MSPS_OFF_CTRL);
  assign wr_adv = wr_in && hit(addr_in, `MSPS_OFF_ADV) && force_adv;

  // counting follows the media link, not the serial one
  assign cnt_step = tx_good_pkt_in && media_link_up_in;

  // advertised word select, shared by pcs and read path
  assign adv_sel = adv_pick(force_adv, adv_sw, adv_live_in);
  assign force_adv_out = force_adv;

  // force bit; the other control bits live elsewhere
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      force_adv <= 1'b0;
    else if (wr_ctrl)
      force_adv <= wdata_in[`MSPS_CTRL_FORCE_BIT];
  end

  // software copy of the advertised word
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      adv_sw <= `MSPS_ADV_RESET;
    else if (wr_adv)
      adv_sw <= wdata_in;
  end

  // registered word to the pcs, one cycle behind the select
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      adv_word_out <= `MSPS_ADV_RESET;
    else
      adv_word_out <= adv_sel;
  end

  // sync loss, cleared by a status read
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sync_lost_l <= 1'b0;
    else
      sync_lost_l <= sticky_next(sync_lost_l, sync_lost_in, rd_pcs);
  end

  // invalid code-group, cleared by a status read
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      cgbad_l <= 1'b0;
    else
      cgbad_l <= sticky_next(cgbad_l, cgbad_in, rd_pcs);
  end

  // alignment error has no clear short of reset
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      align_err_l <= 1'b0;
    else
      align_err_l <= sticky_next(align_err_l, align_err_in, 1'b0);
  end

  // comma realign, cleared by a serial status read
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      realign_l <= 1'b0;
    else
      realign_l <= sticky_next(realign_l, comma_realign_in, rd_ser);
  end

  // signal detection event, cleared by a serial status read
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sig_evt_l <= 1'b0;
    else
      sig_evt_l <= sticky_next(sig_evt_l, sig_det_event_in, rd_ser);
  end

  // comma detect: a missing comma wins over the rearming read
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      comma_l <= `MSPS_COMMA_RESET;
    else if (!comma_det_in)
      comma_l <= 1'b0;
    else if (rd_ser)
      comma_l <= 1'b1;
  end

  // last received partner code word
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      lp_word <= `MSPS_LP_RESET;
    else if (lp_word_valid_in)
      lp_word <= lp_word_in;
  end

  // next count; holds while the media link is down
  always @*
  begin
    next_pkt_cnt = pkt_cnt;
    if (cnt_step)
      next_pkt_cnt = cnt_inc(pkt_cnt);
  end

  // good packet count register
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pkt_cnt <= {`MSPS_CNT_W{1'b0}};
    else
      pkt_cnt <= next_pkt_cnt;
  end

  // control image: only the force bit reads back
  always @*
  begin
    ctrl_word = `MSPS_ZERO16;
    ctrl_word[`MSPS_CTRL_FORCE_BIT] = force_adv;
  end

  // pcs status image; bits 13 and 10 stay zero
  always @*
  begin
    pcs_word = `MSPS_ZERO16;
    pcs_word[`MSPS_PCS_SYNC_BIT] = sync_lost_l;
    pcs_word[`MSPS_PCS_CGBAD_BIT] = cgbad_l;
    pcs_word[`MSPS_PCS_ALIGN_BIT] = align_err_l;
    pcs_word[`MSPS_PCS_RESTART_BIT] = lp_aneg_restart_in;
    pcs_word[`MSPS_PCS_RF_HI:`MSPS_PCS_RF_LO] = remote_fault_in;
    pcs_word[`MSPS_PCS_ABIL_HI:`MSPS_PCS_ABIL_LO] = mac_ability_in;
    pcs_word[`MSPS_PCS_LPCAP_BIT] = lp_aneg_capable_in;
    pcs_word[`MSPS_PCS_LINK_BIT] = link_up_in;
    pcs_word[`MSPS_PCS_ANEG_BIT] = aneg_done_in;
    pcs_word[`MSPS_PCS_SIGDET_BIT] = sig_det_in;
  end

  // serial status image; position reads zero in qsgmii
  always @*
  begin
    ser_word = `MSPS_ZERO16;
    ser_word[`MSPS_SER_REALIGN_BIT] = realign_l;
    ser_word[`MSPS_SER_SIGEVT_BIT] = sig_evt_l;
    // other ports have no qsgmii sync of their own
    ser_word[`MSPS_SER_QSYNC_BIT] = qsgmii_sync_in & is_first_port_in;
    ser_word[`MSPS_SER_COMMA_BIT] = comma_l;
    if (!qsgmii_mode_in)
      ser_word[`MSPS_SER_POS_HI:`MSPS_SER_POS_LO] =
        pos_clamp(comma_pos_in);
  end

  // counter image; active follows the media link
  always @*
  begin
    cnt_word = `MSPS_ZERO16;
    cnt_word[`MSPS_CNT_ACT_BIT] = media_link_up_in;
    cnt_word[`MSPS_CNT_W-1:0] = pkt_cnt;
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    next_rdata = `MSPS_ZERO16;
    if (hit(addr_in, `MSPS_OFF_CTRL))
      next_rdata = ctrl_word;
    else if (hit(addr_in, `MSPS_OFF_PCS_STATUS))
      next_rdata = pcs_word;
    else if (hit(addr_in, `MSPS_OFF_ADV))
      // unforced value is the live word; undefined in transfer mode
      next_rdata = adv_sel;
    else if (hit(addr_in, `MSPS_OFF_PARTNER))
      next_rdata = lp_word;
    else if (hit(addr_in, `MSPS_OFF_SERIAL))
      next_rdata = ser_word;
    else if (hit(addr_in, `MSPS_OFF_TXCNT))
      next_rdata = cnt_word;
  end

  // read data valid only in the cycle after the strobe
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_out <= `MSPS_ZERO16;
    else if (rd_in)
      rdata_out <= next_rdata;
    else
      rdata_out <= `MSPS_ZERO16;
  end

endmodule // msps_status_regs

/* File: sim/msps_status_regs_props.sv */
module msps_chk (
  input wire sys_clk_in, resetn_in, wr_in, rd_in, force_adv_out,
  input wire sync_lost_in, media_link_up_in,
  input wire [4:0] addr_in,
  input wire [15:0] wdata_in, rdata_out, adv_live_in, adv_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // status reads without a sync loss, for the clear check
  wire r11 = rd_in && addr_in == 5'h11;
  wire ok = !sync_lost_in;
  AST_IDLE: assert property (!rd_in |=> rdata_out == 16'h0)
    else $error("read data not idle");
  AST_MUX: assert property (!force_adv_out |=>
    adv_word_out == $past(adv_live_in)) else $error("live word not passed");
  AST_FWR: assert property (wr_in && addr_in == 5'h10 |=>
    force_adv_out == $past(wdata_in[11])) else $error("force bit wrong");
  AST_SYNC: assert property (sync_lost_in ##1 r11 |=> rdata_out[15])
    else $error("sync loss not latched");
  AST_CLR: assert property (r11 && ok ##1 ok ##1 r11 && ok |=>
    !rdata_out[15]) else $error("sync loss not cleared");
  AST_RSV: assert property (r11 |=> rdata_out[13] == 1'h0
    && rdata_out[10] == 1'h0) else $error("reserved bit set");
  AST_TX: assert property (rd_in && addr_in == 5'h15 |=>
    rdata_out[15:14] == {$past(media_link_up_in), 1'h0})
    else $error("counter active wrong");
  AST_POS: assert property (rd_in && addr_in == 5'h14 |=>
    rdata_out[11:8] <= 4'h9 && rdata_out[7:0] == 8'h0)
    else $error("comma field wrong");
  COV_FRC: cover property (wr_in && addr_in == 5'h10 ##1 force_adv_out);
  COV_SYN: cover property (sync_lost_in ##1 r11);
  COV_TX: cover property (rd_in && addr_in == 5'h15 && media_link_up_in);
endmodule // msps_chk

bind msps_status_regs msps_chk i_msps_chk (.*);

/* File: sim/msps_mac_model.sv */
module msps_mac_model (
  input wire sys_clk_in,
  input wire [6:0] req_in,
  output logic [6:0] pulse_out = 7'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // each request becomes a one-cycle event from the link side
  always @(posedge sys_clk_in)
    pulse_out <= req_in;
endmodule // msps_mac_model

/* File: sim/msps_status_regs_tb.sv */
module msps_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = '0, resetn_in = '0, wr_in = '0, rd_in = '0;
  logic [4:0] addr_in = '0;
  logic [15:0] wdata_in = '0, adv_live_in = 16'hc3a5, lp_word_in = '0;
  logic [1:0] remote_fault_in = '0;
  logic [3:0] mac_ability_in = '0, comma_pos_in = '0;
  logic lp_aneg_restart_in = '0, lp_aneg_capable_in = '0, link_up_in = '0;
  logic aneg_done_in = '0, sig_det_in = '0, qsgmii_sync_in = '0;
  logic comma_det_in = '0, is_first_port_in = '0, qsgmii_mode_in = '0;
  logic media_link_up_in = '0;
  logic [6:0] req = '0;
  wire [6:0] p;
  wire [15:0] rdata_out, adv_word_out;
  wire force_adv_out, sync_lost_in, cgbad_in, align_err_in;
  wire comma_realign_in, sig_det_event_in, lp_word_valid_in, tx_good_pkt_in;
  int failures = 0, check_count = 0;
  // events arrive through the far-side model
  assign {tx_good_pkt_in, lp_word_valid_in, sig_det_event_in,
    comma_realign_in, align_err_in, cgbad_in, sync_lost_in} = p;
  msps_status_regs i_msps_status_regs (.*);
  msps_mac_model i_msps_mac_model (.sys_clk_in, .req_in(req), .pulse_out(p));
  // clock
  initial forever #2 sys_clk_in = ~sys_clk_in;
  task chk(input logic [15:0] s, e, input logic [7:0] n);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR item %h exp %h got %h", n, e, s);
    end
  endtask
  task wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_in) {addr_in, wdata_in, wr_in} <= {a, d, 1'h1};
    @(posedge sys_clk_in) wr_in <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task rreg(input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk_in) {addr_in, rd_in} <= {a, 1'h1};
    @(posedge sys_clk_in) rd_in <= 1'h0;
    #1 chk(rdata_out, e, {3'h0, a});
    @(posedge sys_clk_in);
  endtask
  task ev(input logic [6:0] v);
    @(posedge sys_clk_in) req <= v;
    @(posedge sys_clk_in) req <= 7'h0;
    @(posedge sys_clk_in);
  endtask
  task t_adv;
    wreg(5'h10, 16'h0800);
    rreg(5'h12, 16'h0000);
    wreg(5'h12, 16'h1234);
    @(posedge sys_clk_in);
    #1 chk(adv_word_out, 16'h1234, 8'hff);
    wreg(5'h10, 16'h0000);
    wreg(5'h12, 16'h5a5a);
    wreg(5'h10, 16'hffff);
    rreg(5'h12, 16'h1234);
    rreg(5'h10, 16'h0800);
  endtask
  task t_pcs;
    {remote_fault_in, mac_ability_in} <= {2'h1, 4'ha};
    {lp_aneg_restart_in, lp_aneg_capable_in, link_up_in} <= 3'h7;
    sig_det_in <= 1'h1;
    ev(7'h07);
    rreg(5'h11, 16'hd9ad);
    aneg_done_in <= 1'h1;
    rreg(5'h11, 16'h19af);
  endtask
  task t_ser;
    {is_first_port_in, qsgmii_sync_in, comma_det_in} <= 3'h7;
    comma_pos_in <= 4'h7;
    ev(7'h18);
    rreg(5'h14, 16'he700);
    rreg(5'h14, 16'h3700);
    {comma_det_in, comma_pos_in} <= {1'h0, 4'hc};
    rreg(5'h14, 16'h2900);
  endtask
  task t_lp;
    lp_word_in <= 16'hbeef;
    ev(7'h20);
    rreg(5'h13, 16'hbeef);
    rreg(5'h1f, 16'h0000);
  endtask
  // count wraps at 10000 packets, 10001 sent leave it at one, one every three cycles
  task t_cnt;
    media_link_up_in <= 1'h1;
    repeat (10001) ev(7'h40);
    rreg(5'h15, 16'h8001);
    media_link_up_in <= 1'h0;
    ev(7'h40);
    rreg(5'h15, 16'h0001);
  endtask
  task complete_run;
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'h1;
    t_adv;
    t_pcs;
    t_ser;
    t_lp;
    t_cnt;
    complete_run;
  end
  // watchdog well past the expected 120 us
  initial
  begin
    #300us;
    failures++;
    complete_run;
  end
endmodule // msps_status_regs_tb
